/* File: pkg/coam_pkg.sv */
// shared constants and types for the operand addressing and move block
package coam_pkg;
    // operand addressing modes, one per documented mode
    typedef enum logic [2:0] {
        MD_REG_DIRECT,
        MD_REG_INDIRECT,
        MD_DISP,
        MD_INC_DEC,
        MD_ABSOLUTE,
        MD_IMMEDIATE,
        MD_PC_REL,
        MD_MEM_INDIRECT
    } coam_mode_e;

    // operand sizes
    typedef enum logic [1:0] {
        SZ_BYTE,
        SZ_WORD,
        SZ_LONG
    } coam_size_e;

    localparam int unsigned MEM_ADDR_W = 16; // address bits driven to memory
    localparam int unsigned PC_W = 24; // program counter width
    localparam logic [31:0] STEP_BYTE = 32'h0000_0001; // byte step
    localparam logic [31:0] STEP_WORD = 32'h0000_0002; // word step
    localparam logic [31:0] STEP_LONG = 32'h0000_0004; // longword step
    // condition code bit positions
    localparam int unsigned CCR_I = 7;
    localparam int unsigned CCR_H = 5;
    localparam int unsigned CCR_N = 3;
    localparam int unsigned CCR_Z = 2;
    localparam int unsigned CCR_V = 1;
    localparam int unsigned CCR_C = 0;
    localparam logic [7:0] CCR_RESET = 8'h80; // interrupts masked at reset

    // keep only the bits of the operand size
    function automatic logic [31:0] size_data(coam_size_e sz,
                                              logic [31:0] d);
        logic [31:0] r;
        r = d;
        if (sz == SZ_BYTE) begin
            r = {24'h00_0000, d[7:0]};
        end else if (sz == SZ_WORD) begin
            r = {16'h0000, d[15:0]};
        end
        return r;
    endfunction

    // sign bit of the operand at its size
    function automatic logic sign_bit(coam_size_e sz, logic [31:0] d);
        logic s;
        s = d[31];
        if (sz == SZ_BYTE) begin
            s = d[7];
        end else if (sz == SZ_WORD) begin
            s = d[15];
        end
        return s;
    endfunction
endpackage

/* File: pkg/coam_ea_if.sv */
// carrier between the top block and its effective address calculator
`timescale 1ns/10ps
interface coam_ea_if;
    coam_pkg::coam_mode_e mode; // addressing mode
    logic predec; // pre-decrement instead of post-increment
    coam_pkg::coam_size_e size; // operand size
    logic [31:0] reg_value; // selected address register contents
    logic [31:0] disp; // displacement
    logic disp_short; // displacement is 16 bits wide
    logic [31:0] abs_val; // absolute address or immediate
    logic [coam_pkg::PC_W-1:0] pc; // program counter
    logic [31:0] ea; // full effective address
    logic [31:0] new_reg; // register value after adjust
    logic [31:0] step; // 1, 2 or 4

    modport calc (
        input mode, predec, size, reg_value, disp, disp_short, abs_val, pc,
        output ea, new_reg, step
    );
    modport user (
        output mode, predec, size, reg_value, disp, disp_short, abs_val, pc,
        input ea, new_reg, step
    );
endinterface

/* File: logic/coam_ea_calc.sv */
// effective address calculator for all addressing modes
`timescale 1ns/10ps
module coam_ea_calc (
    coam_ea_if.calc bus
);
    logic [31:0] disp_ext; // displacement after sign extension

    // short displacement is sign extended before the add
    always_comb begin
        disp_ext = bus.disp;
        if (bus.disp_short) begin
            disp_ext = {{16{bus.disp[15]}}, bus.disp[15:0]};
        end
    end

    // step by operand size
    always_comb begin
        case (bus.size)
            coam_pkg::SZ_BYTE: bus.step = coam_pkg::STEP_BYTE;
            coam_pkg::SZ_WORD: bus.step = coam_pkg::STEP_WORD;
            default: bus.step = coam_pkg::STEP_LONG;
        endcase
    end

    // address per mode; register direct and immediate need none
    always_comb begin
        bus.ea = bus.reg_value;
        bus.new_reg = bus.reg_value;
        case (bus.mode)
            coam_pkg::MD_DISP: begin
                bus.ea = bus.reg_value + disp_ext;
            end
            coam_pkg::MD_INC_DEC: begin
                if (bus.predec) begin
                    // decrement first, then access the new address
                    bus.ea = bus.reg_value - bus.step;
                    bus.new_reg = bus.reg_value - bus.step;
                end else begin
                    bus.new_reg = bus.reg_value + bus.step;
                end
            end
            coam_pkg::MD_ABSOLUTE: begin
                bus.ea = bus.abs_val;
            end
            coam_pkg::MD_PC_REL: begin
                bus.ea = {8'h00, bus.pc} + disp_ext;
            end
            coam_pkg::MD_MEM_INDIRECT: begin
                // vector slot sits in the first 256 bytes
                bus.ea = {24'h00_0000, bus.abs_val[7:0]};
            end
            default: begin
                bus.ea = bus.reg_value;
            end
        endcase
    end
endmodule

/* File: logic/cpu_operand_address_mov.sv */
// operand addressing and move execution unit of a small cpu core
// Overview of operation
// - eight operand addressing modes are supported
// - register direct moves register contents, no memory
// - displacement adds to register; short one sign-extended
// - increment or decrement by 1, 2 or 4
// - only low 16 address bits reach memory
// - byte pre-decrement store decrements, then writes
// - negative flag takes result sign bit
// - zero flag set when result is zero
`timescale 1ns/10ps
module cpu_operand_address_mov (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic op_valid,
    input wire coam_pkg::coam_mode_e op_mode,
    input wire logic op_predec,
    input wire coam_pkg::coam_size_e op_size,
    input wire logic op_store,
    input wire logic [31:0] op_reg_value,
    input wire logic [31:0] op_src_data,
    input wire logic [31:0] op_disp,
    input wire logic op_disp_short,
    input wire logic [31:0] op_abs,
    input wire logic [coam_pkg::PC_W-1:0] op_pc,
    output logic op_ready,
    output logic mem_req,
    output logic mem_we,
    output logic [coam_pkg::MEM_ADDR_W-1:0] mem_addr,
    output logic [31:0] mem_wdata,
    output coam_pkg::coam_size_e mem_size,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic done,
    output logic [31:0] result,
    output logic areg_wr,
    output logic [31:0] areg_value,
    output logic [7:0] ccr
);
    typedef enum logic [1:0] {ST_IDLE, ST_VEC, ST_ACC} coam_state_e;

    coam_state_e state_q; // sequencer state
    coam_pkg::coam_size_e size_q; // operand size in flight
    logic store_q; // access writes memory
    logic incdec_q; // address register is written back
    logic [31:0] data_q; // store data
    logic [31:0] new_reg_q; // adjusted address register
    logic [31:0] base_q; // register contents at start
    logic [31:0] step_q; // step taken at start
    logic predec_q; // pre-decrement in flight
    logic ready_q, req_q, we_q, done_q, areg_wr_q;
    logic [coam_pkg::MEM_ADDR_W-1:0] addr_q; // memory address
    logic [31:0] wdata_q, result_q, areg_value_q;
    coam_pkg::coam_size_e msize_q; // size shown to memory
    logic [7:0] ccr_q; // condition codes
    logic start; // request accepted this cycle
    logic no_mem; // mode needs no memory access
    logic fin; // move completes this cycle
    logic [31:0] fin_val; // moved value at its size
    logic [coam_pkg::MEM_ADDR_W-1:0] ea_low; // address less its top bits
    logic [coam_pkg::MEM_ADDR_W-1:0] vec_low; // vector read from memory

    coam_ea_if ea_bus ();

    // feed the calculator from the live request
    assign ea_bus.mode = op_mode;
    assign ea_bus.predec = op_predec;
    assign ea_bus.size = op_size;
    assign ea_bus.reg_value = op_reg_value;
    assign ea_bus.disp = op_disp;
    assign ea_bus.disp_short = op_disp_short;
    assign ea_bus.abs_val = op_abs;
    assign ea_bus.pc = op_pc;

    coam_ea_calc u_calc (
        .bus(ea_bus)
    );

    assign start = op_valid && ready_q;
    // direct and immediate take the operand without a bus cycle
    assign no_mem = (op_mode == coam_pkg::MD_REG_DIRECT) ||
                    (op_mode == coam_pkg::MD_IMMEDIATE);
    assign fin = (start && no_mem) || (state_q == ST_ACC && mem_ack);
    // only the low address bits ever reach memory
    assign ea_low = ea_bus.ea[coam_pkg::MEM_ADDR_W-1:0];
    assign vec_low = mem_rdata[coam_pkg::MEM_ADDR_W-1:0];

    // value that the move transfers, cut to its size
    always_comb begin
        fin_val = coam_pkg::size_data(size_q, store_q ? data_q : mem_rdata);
        if (state_q == ST_IDLE) begin
            if (op_mode == coam_pkg::MD_REG_DIRECT) begin
                fin_val = coam_pkg::size_data(op_size, op_src_data);
            end else begin
                fin_val = coam_pkg::size_data(op_size, op_abs);
            end
        end
    end

    // sequencer and memory request; req holds until acknowledged
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
            ready_q <= 1'b1;
            req_q <= 1'b0;
            we_q <= 1'b0;
            addr_q <= '0;
            wdata_q <= '0;
            msize_q <= coam_pkg::SZ_BYTE;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start && !no_mem) begin
                        ready_q <= 1'b0;
                        req_q <= 1'b1;
                        addr_q <= ea_low;
                        if (op_mode == coam_pkg::MD_MEM_INDIRECT) begin
                            // fetch the 16-bit vector first
                            state_q <= ST_VEC;
                            we_q <= 1'b0;
                            msize_q <= coam_pkg::SZ_WORD;
                        end else begin
                            state_q <= ST_ACC;
                            we_q <= op_store;
                            msize_q <= op_size;
                            wdata_q <= coam_pkg::size_data(op_size,
                                                           op_src_data);
                        end
                    end
                end
                ST_VEC: begin
                    if (mem_ack) begin
                        state_q <= ST_ACC;
                        addr_q <= vec_low;
                        we_q <= store_q;
                        msize_q <= size_q;
                        wdata_q <= data_q;
                    end
                end
                default: begin
                    if (mem_ack) begin
                        state_q <= ST_IDLE;
                        ready_q <= 1'b1;
                        req_q <= 1'b0;
                        we_q <= 1'b0;
                    end
                end
            endcase
        end
    end

    // capture of the request fields
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            size_q <= coam_pkg::SZ_BYTE;
            store_q <= 1'b0;
            incdec_q <= 1'b0;
            predec_q <= 1'b0;
            data_q <= '0;
            new_reg_q <= '0;
            base_q <= '0;
            step_q <= '0;
        end else if (start) begin
            size_q <= op_size;
            store_q <= op_store;
            incdec_q <= (op_mode == coam_pkg::MD_INC_DEC);
            predec_q <= op_predec;
            data_q <= coam_pkg::size_data(op_size, op_src_data);
            new_reg_q <= ea_bus.new_reg;
            base_q <= op_reg_value;
            step_q <= ea_bus.step;
        end
    end

    // completion pulse, result and register write-back
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            done_q <= 1'b0;
            result_q <= '0;
            areg_wr_q <= 1'b0;
            areg_value_q <= '0;
        end else begin
            done_q <= fin;
            areg_wr_q <= fin && state_q == ST_ACC && incdec_q;
            if (fin) begin
                result_q <= fin_val;
                areg_value_q <= new_reg_q;
            end
        end
    end

    // flags: n and z from the moved value, v cleared, rest kept
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ccr_q <= coam_pkg::CCR_RESET;
        end else if (fin) begin
            // the sign sits at the top bit of the moved size
            if (state_q == ST_IDLE) begin
                ccr_q[coam_pkg::CCR_N] <=
                    coam_pkg::sign_bit(op_size, fin_val);
            end else begin
                ccr_q[coam_pkg::CCR_N] <=
                    coam_pkg::sign_bit(size_q, fin_val);
            end
            ccr_q[coam_pkg::CCR_Z] <= (fin_val == 32'h0000_0000);
            ccr_q[coam_pkg::CCR_V] <= 1'b0;
        end
    end

    assign op_ready = ready_q;
    assign mem_req = req_q;
    assign mem_we = we_q;
    assign mem_addr = addr_q;
    assign mem_wdata = wdata_q;
    assign mem_size = msize_q;
    assign done = done_q;
    assign result = result_q;
    assign areg_wr = areg_wr_q;
    assign areg_value = areg_value_q;
    assign ccr = ccr_q;

    // helper: result of the finished move cut to its size
    logic [31:0] res_masked;
    assign res_masked = coam_pkg::size_data(size_q, result_q);

    // every check below runs on the core clock and sleeps in reset
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_direct_start;
        start && op_mode == coam_pkg::MD_REG_DIRECT;
    endsequence
    sequence s_done_no_bus;
        done_q && !req_q;
    endsequence

    a_direct_no_bus: assert property (
        s_direct_start |=> s_done_no_bus)
        else $error("register direct move touched memory");
    a_direct_value: assert property (
        s_direct_start |=> result_q ==
            $past(coam_pkg::size_data(op_size, op_src_data)))
        else $error("register direct result wrong");
    a_disp_short_sext: assert property (
        (op_mode == coam_pkg::MD_DISP && op_disp_short) |->
            ea_bus.ea == op_reg_value + {{16{op_disp[15]}}, op_disp[15:0]})
        else $error("short displacement not sign extended");
    a_step_adjust: assert property (
        areg_wr_q |-> areg_value_q ==
            (predec_q ? base_q - step_q : base_q + step_q))
        else $error("address register step wrong");
    a_step_size: assert property (
        start |-> ea_bus.step == (op_size == coam_pkg::SZ_BYTE ? 32'h1 :
                  op_size == coam_pkg::SZ_WORD ? 32'h2 : 32'h4))
        else $error("step does not match operand size");
    a_addr_trunc: assert property (
        (start && !no_mem) |=> mem_req &&
            mem_addr == $past(ea_bus.ea[15:0]))
        else $error("memory address not low 16 bits of ea");
    a_predec_store: assert property (
        (start && op_mode == coam_pkg::MD_INC_DEC && op_predec && op_store)
        |=> mem_we && mem_addr == $past(op_reg_value[15:0] -
                                        ea_bus.step[15:0]))
        else $error("pre-decrement store to wrong address");
    a_flag_neg: assert property (
        done_q |-> ccr_q[coam_pkg::CCR_N] ==
            coam_pkg::sign_bit(size_q, res_masked))
        else $error("negative flag wrong");
    a_flag_zero: assert property (
        done_q |-> ccr_q[coam_pkg::CCR_Z] == (result_q == 32'h0))
        else $error("zero flag wrong");
    a_flag_keep: assert property (
        done_q |-> !ccr_q[coam_pkg::CCR_V] &&
            ccr_q[7:4] == $past(ccr_q[7:4]) &&
            ccr_q[coam_pkg::CCR_C] == $past(ccr_q[coam_pkg::CCR_C]))
        else $error("move disturbed i, h, v or c");
    a_access_ends: assert property (
        (state_q == ST_ACC && mem_ack) |=> done_q && op_ready)
        else $error("access did not complete the move");
endmodule

/* File: verification/coam_mem_model.sv */
// memory bus partner model: acks after a chosen wait, returns address data
`timescale 1ns/10ps
module coam_mem_model (
    input wire logic clk,
    input wire logic mem_req,
    input wire logic [coam_pkg::MEM_ADDR_W-1:0] mem_addr,
    input wire logic [1:0] ack_delay,
    input wire logic zero_data,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [1:0] wait_cnt; // cycles the current access has waited

    initial begin
        mem_ack = 1'b0;
        mem_rdata = 32'h0000_0000;
        wait_cnt = 2'h0;
    end

    // ack after ack_delay cycles; data lines toggle whenever not valid,
    // so the device cannot live on stale read data
    always @(negedge clk) begin
        if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            wait_cnt <= 2'h0;
        end else if (mem_req && wait_cnt == ack_delay) begin
            mem_ack <= 1'b1;
            mem_rdata <= zero_data ? 32'h0000_0000 :
                {~mem_addr, mem_addr + 16'h1234};
        end else begin
            mem_rdata <= ~mem_rdata;
            if (mem_req) begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule

/* File: verification/cpu_operand_address_mov_tb_top.sv */
// self-checking testbench for the operand addressing and move unit
`timescale 1ns/10ps
module cpu_operand_address_mov_tb_top;
    logic clk = 1'b0; // core clock
    logic reset_n = 1'b0; // synchronous reset
    logic op_valid = 1'b0; // request strobe
    coam_pkg::coam_mode_e op_mode = coam_pkg::MD_REG_DIRECT;
    coam_pkg::coam_size_e op_size = coam_pkg::SZ_BYTE;
    logic op_predec = 1'b0;
    logic op_store = 1'b0;
    logic op_disp_short = 1'b0;
    logic [31:0] op_reg_value = 32'h0000_0000;
    logic [31:0] op_src_data = 32'h0000_0000;
    logic [31:0] op_disp = 32'h0000_0000;
    logic [31:0] op_abs = 32'h0000_0000;
    logic [coam_pkg::PC_W-1:0] op_pc = 24'h00_0000;
    logic [1:0] ack_delay = 2'h0; // memory stall per access
    logic zero_data = 1'b0; // memory returns zero
    logic op_ready, mem_req, mem_we, mem_ack, done, areg_wr;
    logic [coam_pkg::MEM_ADDR_W-1:0] mem_addr;
    logic [31:0] mem_wdata, mem_rdata, result, areg_value;
    coam_pkg::coam_size_e mem_size;
    logic [7:0] ccr;
    logic [7:0] ccr_m = 8'h80; // model of the flag register
    logic [50:0] acc_q[$]; // completed bus accesses
    int seed = 97548;
    int bad_count = 0;
    int checks_done = 0;
    int cycles = 0;

    cpu_operand_address_mov uut (.clk(clk), .reset_n(reset_n),
        .op_valid(op_valid), .op_mode(op_mode), .op_predec(op_predec),
        .op_size(op_size), .op_store(op_store),
        .op_reg_value(op_reg_value), .op_src_data(op_src_data),
        .op_disp(op_disp), .op_disp_short(op_disp_short), .op_abs(op_abs),
        .op_pc(op_pc), .op_ready(op_ready), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_size(mem_size), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .done(done), .result(result), .areg_wr(areg_wr),
        .areg_value(areg_value), .ccr(ccr));

    coam_mem_model mem (.clk(clk), .mem_req(mem_req), .mem_addr(mem_addr),
        .ack_delay(ack_delay), .zero_data(zero_data), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));

    // 100 mhz clock
    always #5 clk = ~clk;

    // log each access; read data is not part of the record
    always @(posedge clk) begin
        if (reset_n && mem_req && mem_ack) begin
            acc_q.push_back({mem_we, mem_size, mem_addr,
                mem_we ? mem_wdata : 32'h0000_0000});
        end
    end

    // cut a hang short; no legal run gets near this ceiling
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    // one comparison; widths are zero-extended to the widest record
    task automatic chk(input string nm, input logic [50:0] exp,
                       input logic [50:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one move; called at a falling edge, returns at the done edge with
    // op_valid still high so a busy unit sees (and must ignore) it
    task automatic run_op(input coam_pkg::coam_mode_e md,
        input coam_pkg::coam_size_e sz, input logic st, input logic pd);
        logic [31:0] ea, stp, val, vd, msk, dx;
        logic [50:0] exp_q[$];
        logic n_b, z_b;
        int k;
        op_reg_value = $random(seed);
        op_src_data = $random(seed);
        op_disp = $random(seed);
        op_disp_short = 1'($random(seed));
        op_abs = $random(seed);
        op_pc = 24'($random(seed));
        ack_delay = 2'($random(seed));
        zero_data = ($random(seed) % 4 == 0);
        if (zero_data) begin
            op_src_data = 32'h0000_0000;
            op_abs = 32'h0000_0000;
        end
        if (md == coam_pkg::MD_MEM_INDIRECT) begin
            st = 1'b0;
        end
        op_mode = md;
        op_size = sz;
        op_store = st;
        op_predec = pd;
        op_valid = 1'b1;
        acc_q.delete();
        stp = (sz == coam_pkg::SZ_BYTE) ? 32'h1 :
            (sz == coam_pkg::SZ_WORD) ? 32'h2 : 32'h4;
        msk = (sz == coam_pkg::SZ_BYTE) ? 32'hff :
            (sz == coam_pkg::SZ_WORD) ? 32'hffff : 32'hffff_ffff;
        // short displacement counts as a signed 16-bit value
        dx = op_disp_short ? {{16{op_disp[15]}}, op_disp[15:0]} :
            op_disp;
        ea = op_reg_value;
        case (md)
            coam_pkg::MD_DISP: begin
                ea = op_reg_value + dx;
            end
            coam_pkg::MD_INC_DEC: begin
                ea = pd ? op_reg_value - stp : op_reg_value;
            end
            coam_pkg::MD_ABSOLUTE: ea = op_abs;
            coam_pkg::MD_PC_REL: ea = {8'h00, op_pc} + dx;
            coam_pkg::MD_MEM_INDIRECT: begin
                // vector is a word read from the zero-extended slot
                exp_q.push_back({1'b0, 2'(coam_pkg::SZ_WORD), 8'h00,
                    op_abs[7:0], 32'h0});
                vd = zero_data ? 32'h0 : {8'hff, ~op_abs[7:0],
                    8'h00, op_abs[7:0]} + 32'h1234;
                ea = {16'h0000, vd[15:0]};
            end
            default: ;
        endcase
        vd = zero_data ? 32'h0 : {~ea[15:0], ea[15:0] + 16'h1234};
        val = (md == coam_pkg::MD_IMMEDIATE) ? op_abs :
            (md == coam_pkg::MD_REG_DIRECT || st) ? op_src_data : vd;
        val = val & msk;
        n_b = (val & ((msk >> 1) + 32'h1)) != 32'h0;
        z_b = (val == 32'h0);
        ccr_m = {ccr_m[7:4], n_b, z_b, 1'b0, ccr_m[0]};
        if (md != coam_pkg::MD_REG_DIRECT && md != coam_pkg::MD_IMMEDIATE)
        begin
            exp_q.push_back({st, 2'(sz), ea[15:0], st ? val : 32'h0});
        end
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (done !== 1'b1 && k < 40);
        chk("done", 51'h1, {50'h0, done});
        chk("result", {19'h0, val}, {19'h0, result});
        chk("ccr n", {50'h0, n_b}, {50'h0, ccr[coam_pkg::CCR_N]});
        chk("ccr z", {50'h0, z_b}, {50'h0, ccr[coam_pkg::CCR_Z]});
        chk("ccr", {43'h0, ccr_m}, {43'h0, ccr});
        chk("areg_wr", {50'h0, md == coam_pkg::MD_INC_DEC},
            {50'h0, areg_wr});
        if (md == coam_pkg::MD_INC_DEC) begin
            chk("areg_value", {19'h0, pd ? op_reg_value - stp :
                op_reg_value + stp}, {19'h0, areg_value});
        end
        chk("access count", 51'(exp_q.size()), 51'(acc_q.size()));
        for (int i = 0; i < exp_q.size() && i < acc_q.size(); i++) begin
            chk("access", exp_q[i], acc_q[i]);
        end
    endtask

    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        chk("ready after reset", 51'h1, {50'h0, op_ready});
        chk("ccr after reset", 51'h80, {43'h0, ccr});
        chk("req after reset", 51'h0, {50'h0, mem_req});
        // every mode, size and adjust sense; both directions except memory indirect, which run_op turns into reads
        for (int m = 0; m < 8; m++) begin
            for (int s = 0; s < 3; s++) begin
                for (int d = 0; d < 4; d++) begin
                    run_op(coam_pkg::coam_mode_e'(m),
                        coam_pkg::coam_size_e'(s), d[0], d[1]);
                end
            end
        end
        // random mix, back-to-back direct and immediate moves included
        repeat (60) begin
            run_op(coam_pkg::coam_mode_e'($random(seed) & 7),
                coam_pkg::coam_size_e'($unsigned($random(seed)) % 3),
                1'($random(seed)), 1'($random(seed)));
        end
        run_op(coam_pkg::MD_INC_DEC, coam_pkg::SZ_BYTE, 1'b1, 1'b1);
        op_valid = 1'b0;
        repeat (3) @(negedge clk);
        chk("no stray done", 51'h0, {50'h0, done});
        give_verdict();
    end
endmodule
